/* File: mmd_pkg.sv */
// Shared constants, types and the boot ROM contents for the memory map decoder
package mmd_pkg;

   localparam int DW = 16;
   localparam int AW = 16;
   localparam int RAM_AW = 9;

   typedef enum logic [1:0] {
      SP_PROG = 2'b00,
      SP_DATA = 2'b01,
      SP_IO   = 2'b10
   } mmd_space_t;

   typedef enum logic [3:0] {
      RG_ILLEGAL  = 4'h0,
      RG_RESERVED = 4'h1,
      RG_B0       = 4'h2,
      RG_B1       = 4'h3,
      RG_B2       = 4'h4,
      RG_SARAM    = 4'h5,
      RG_BOOT     = 4'h6,
      RG_VECTOR   = 4'h7,
      RG_PASSWORD = 4'h8,
      RG_FLASH    = 4'h9,
      RG_MMREG    = 4'ha,
      RG_PERIPH   = 4'hb,
      RG_EXTERNAL = 4'hc,
      RG_CONFIG   = 4'hd
   } mmd_region_t;

   // Data space
   localparam logic [15:0] DATA_MMREG_LAST   = 16'h005f;
   localparam logic [15:0] DATA_B2_LAST      = 16'h007f;
   localparam logic [15:0] DATA_ILL0_LAST    = 16'h00ff;
   localparam logic [15:0] DATA_B0_LAST      = 16'h02ff;
   localparam logic [15:0] DATA_B1_LAST      = 16'h04ff;
   localparam logic [15:0] DATA_ILL1_LAST    = 16'h07ff;
   localparam logic [15:0] DATA_SA_LAST      = 16'h09ff;
   localparam logic [15:0] DATA_PERIPH_FIRST = 16'h7000;
   localparam logic [15:0] DATA_PERIPH_LAST  = 16'h7fff;

   // Program space
   localparam logic [15:0] PROG_VEC_LAST     = 16'h003f;
   localparam logic [15:0] PROG_PWD_LAST     = 16'h0043;
   localparam logic [15:0] PROG_BOOT_LAST    = 16'h00ff;
   localparam logic [15:0] PROG_FLASH_LAST   = 16'h7fff;
   localparam logic [15:0] PROG_SA_LAST      = 16'h81ff;
   localparam logic [15:0] PROG_B0_FIRST     = 16'hfe00;

   // I/O space control words
   localparam logic [15:0] IO_CFG_ADDR       = 16'hfff0;
   localparam logic [15:0] IO_STAT_ADDR      = 16'hfff1;

   // Configuration word layout
   localparam int CFG_W         = 4;
   localparam int CFG_PLACE_BIT = 0;
   localparam int CFG_DSRAM_BIT = 1;
   localparam int CFG_PSRAM_BIT = 2;
   localparam int CFG_BOOT_BIT  = 3;
   localparam logic [CFG_W-1:0] CFG_RESET = 4'h0;

   localparam int B0_DEPTH = 256;
   localparam int B1_DEPTH = 256;
   localparam int B2_DEPTH = 32;
   localparam int SA_DEPTH = 512;

   // Boot ROM image tag; arbitrary value
   localparam logic [7:0] ROM_TAG = 8'h5a;

   function automatic logic [DW-1:0] mmd_rom_word(input logic [7:0] a);
      return {ROM_TAG ^ a, a};
   endfunction

endpackage

/* File: mmd_mem_if.sv */
// Port bundle between the decoder and one on-chip RAM block
`timescale 1ns/1ps
interface mmd_mem_if;
   logic        we;
   logic [8:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport ctrl (output we, output addr, output wdata, input rdata);
   modport mem  (input we, input addr, input wdata, output rdata);
endinterface

/* File: mmd_ram.sv */
// Flip-flop RAM block with asynchronous read
`timescale 1ns/1ps
module mmd_ram #(
   parameter int DEPTH = 256,
   parameter int IW    = 8
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Access port
   mmd_mem_if.mem   port
);
   import mmd_pkg::*;

   logic [DW-1:0] mem_r   [DEPTH];
   logic [DW-1:0] mem_nxt [DEPTH];

   assign port.rdata = mem_r[port.addr[IW-1:0]];

   for (genvar i = 0; i < DEPTH; i++) begin : g_word
      always_comb begin
         mem_nxt[i] = mem_r[i];
         if (port.we && port.addr[IW-1:0] == IW'(i)) begin
            mem_nxt[i] = port.wdata;
         end
      end
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            mem_r[i] <= 16'h0000;
         end else if (clk_en) begin
            mem_r[i] <= mem_nxt[i];
         end
      end
   end

endmodule

/* File: mmd_decoder.sv */
// Core memory map decoder: aliasing, boot overlay, RAM gating and control words
`timescale 1ns/1ps
module mmd_decoder (
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire logic               clk_en,
   // Core memory bus
   input  wire mmd_pkg::mmd_space_t space,
   input  wire logic [15:0]        addr,
   input  wire logic [15:0]        wr_data,
   input  wire logic               wr_stb,
   input  wire logic               rd_stb,
   output logic [15:0]             rd_data_r,
   // Decode status
   output mmd_pkg::mmd_region_t    acc_region_r,
   output logic                    block_zero_program_place,
   output logic                    data_single_ram_enable,
   output logic                    program_single_ram_enable,
   output logic                    boot_rom_enable
);
   import mmd_pkg::*;

   logic [CFG_W-1:0] cfg_r;
   logic [CFG_W-1:0] cfg_nxt;
   logic [15:0]      rd_data_nxt;
   mmd_region_t      acc_region_nxt;
   mmd_region_t      reg_cur;
   logic             place;
   logic             dsram_en;
   logic             psram_en;
   logic             boot_en;
   logic             hit_wr;

   mmd_mem_if b0_if ();
   mmd_mem_if b1_if ();
   mmd_mem_if b2_if ();
   mmd_mem_if sa_if ();

   assign place    = cfg_r[CFG_PLACE_BIT];
   assign dsram_en = cfg_r[CFG_DSRAM_BIT];
   assign psram_en = cfg_r[CFG_PSRAM_BIT];
   assign boot_en  = cfg_r[CFG_BOOT_BIT];

   assign block_zero_program_place  = cfg_r[CFG_PLACE_BIT];
   assign data_single_ram_enable    = cfg_r[CFG_DSRAM_BIT];
   assign program_single_ram_enable = cfg_r[CFG_PSRAM_BIT];
   assign boot_rom_enable           = cfg_r[CFG_BOOT_BIT];

   // Address decode; the alias ranges fall out of indexing on low bits only
   always_comb begin
      reg_cur = RG_RESERVED;
      case (space)
         SP_DATA: begin
            if (addr <= DATA_MMREG_LAST) begin
               reg_cur = RG_MMREG;
            end else if (addr <= DATA_B2_LAST) begin
               reg_cur = RG_B2;
            end else if (addr <= DATA_ILL0_LAST) begin
               reg_cur = RG_ILLEGAL;
            end else if (addr <= DATA_B0_LAST) begin
               reg_cur = place ? RG_RESERVED : RG_B0;
            end else if (addr <= DATA_B1_LAST) begin
               reg_cur = RG_B1;
            end else if (addr <= DATA_ILL1_LAST) begin
               reg_cur = RG_ILLEGAL;
            end else if (addr <= DATA_SA_LAST) begin
               reg_cur = dsram_en ? RG_SARAM : RG_RESERVED;
            end else if (addr < DATA_PERIPH_FIRST) begin
               reg_cur = RG_RESERVED;
            end else if (addr <= DATA_PERIPH_LAST) begin
               reg_cur = RG_PERIPH;
            end else begin
               reg_cur = RG_EXTERNAL;
            end
         end
         SP_PROG: begin
            if (boot_en && addr <= PROG_BOOT_LAST) begin
               reg_cur = RG_BOOT;
            end else if (addr <= PROG_VEC_LAST) begin
               reg_cur = RG_VECTOR;
            end else if (addr <= PROG_PWD_LAST) begin
               reg_cur = RG_PASSWORD;
            end else if (addr <= PROG_FLASH_LAST) begin
               reg_cur = RG_FLASH;
            end else if (addr <= PROG_SA_LAST) begin
               reg_cur = psram_en ? RG_SARAM : RG_RESERVED;
            end else if (addr < PROG_B0_FIRST) begin
               reg_cur = RG_RESERVED;
            end else begin
               reg_cur = place ? RG_B0 : RG_RESERVED;
            end
         end
         SP_IO: begin
            if (addr == IO_CFG_ADDR || addr == IO_STAT_ADDR) begin
               reg_cur = RG_CONFIG;
            end else begin
               reg_cur = RG_EXTERNAL;
            end
         end
         default: reg_cur = RG_ILLEGAL;
      endcase
   end

   // Only a mapped RAM region ever sees a write enable
   assign hit_wr = wr_stb && clk_en;

   assign b0_if.we    = hit_wr && reg_cur == RG_B0;
   assign b0_if.addr  = {1'b0, addr[7:0]};
   assign b0_if.wdata = wr_data;
   assign b1_if.we    = hit_wr && reg_cur == RG_B1;
   assign b1_if.addr  = {1'b0, addr[7:0]};
   assign b1_if.wdata = wr_data;
   assign b2_if.we    = hit_wr && reg_cur == RG_B2;
   assign b2_if.addr  = {4'h0, addr[4:0]};
   assign b2_if.wdata = wr_data;
   assign sa_if.we    = hit_wr && reg_cur == RG_SARAM;
   assign sa_if.addr  = addr[8:0];
   assign sa_if.wdata = wr_data;

   mmd_ram #(.DEPTH(B0_DEPTH), .IW(8)) u_b0 (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .port    (b0_if)
   );
   mmd_ram #(.DEPTH(B1_DEPTH), .IW(8)) u_b1 (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .port    (b1_if)
   );
   mmd_ram #(.DEPTH(B2_DEPTH), .IW(5)) u_b2 (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .port    (b2_if)
   );
   mmd_ram #(.DEPTH(SA_DEPTH), .IW(9)) u_sa (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clk_en  (clk_en),
      .port    (sa_if)
   );

   // Read data stands one cycle only, so it returns to zero without a strobe
   always_comb begin
      cfg_nxt        = cfg_r;
      rd_data_nxt    = 16'h0000;
      acc_region_nxt = acc_region_r;
      if (wr_stb || rd_stb) begin
         acc_region_nxt = reg_cur;
      end
      if (wr_stb && space == SP_IO && addr == IO_CFG_ADDR) begin
         cfg_nxt = wr_data[CFG_W-1:0];
      end
      if (rd_stb) begin
         case (reg_cur)
            RG_B0:    rd_data_nxt = b0_if.rdata;
            RG_B1:    rd_data_nxt = b1_if.rdata;
            RG_B2:    rd_data_nxt = b2_if.rdata;
            RG_SARAM: rd_data_nxt = sa_if.rdata;
            RG_BOOT:  rd_data_nxt = mmd_rom_word(addr[7:0]);
            RG_CONFIG: begin
               if (addr == IO_CFG_ADDR) begin
                  rd_data_nxt = {12'h000, cfg_r};
               end else begin
                  rd_data_nxt = {12'h000, acc_region_r};
               end
            end
            // Flash, vectors, passwords and peripherals live outside this block
            default:  rd_data_nxt = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r        <= CFG_RESET;
         rd_data_r    <= 16'h0000;
         acc_region_r <= RG_ILLEGAL;
      end else if (clk_en) begin
         cfg_r        <= cfg_nxt;
         rd_data_r    <= rd_data_nxt;
         acc_region_r <= acc_region_nxt;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   prog_b0_alias_a: assert property (
      (clk_en && wr_stb && space == SP_PROG && addr[15:8] == 8'hfe && place)
      ##1 (clk_en && rd_stb && space == SP_PROG && addr == {8'hff, $past(addr[7:0])})
      |=> rd_data_r == $past(wr_data, 2))
      else $error("program alias of block zero returned a different word");

   data_b0_alias_a: assert property (
      (clk_en && wr_stb && space == SP_DATA && addr[15:8] == 8'h01 && !place)
      ##1 (clk_en && rd_stb && space == SP_DATA && addr == {8'h02, $past(addr[7:0])})
      |=> rd_data_r == $past(wr_data, 2))
      else $error("data alias of block zero returned a different word");

   data_b1_alias_a: assert property (
      (clk_en && wr_stb && space == SP_DATA && addr[15:8] == 8'h04)
      ##1 (clk_en && rd_stb && space == SP_DATA && addr == {8'h03, $past(addr[7:0])})
      |=> rd_data_r == $past(wr_data, 2))
      else $error("alias of block one returned a different word");

   boot_overlay_a: assert property (
      (clk_en && rd_stb && space == SP_PROG && addr <= PROG_BOOT_LAST && boot_en)
      |=> acc_region_r == RG_BOOT && rd_data_r == mmd_rom_word($past(addr[7:0])))
      else $error("boot ROM overlay not applied");

   pwd_region_a: assert property (
      (clk_en && rd_stb && space == SP_PROG && addr[15:2] == 14'h0010 && !boot_en)
      |=> acc_region_r == RG_PASSWORD)
      else $error("password location not decoded as such");

   vector_region_a: assert property (
      (clk_en && rd_stb && space == SP_PROG && addr <= PROG_VEC_LAST && !boot_en)
      |=> acc_region_r == RG_VECTOR ##1 ($past(rd_stb || wr_stb) || acc_region_r == RG_VECTOR))
      else $error("vector area not decoded as such");

   data_sa_gate_a: assert property (
      (clk_en && rd_stb && space == SP_DATA && addr[15:9] == 7'h04 && !dsram_en)
      |=> acc_region_r == RG_RESERVED && rd_data_r == 16'h0000)
      else $error("data single RAM visible while disabled");

   prog_sa_gate_a: assert property (
      (clk_en && wr_stb && space == SP_PROG && addr[15:9] == 7'h40)
      |-> sa_if.we == psram_en)
      else $error("program single RAM write gating wrong");

   reserved_write_a: assert property (
      (wr_stb && (reg_cur == RG_RESERVED || reg_cur == RG_ILLEGAL))
      |-> !b0_if.we && !b1_if.we && !b2_if.we && !sa_if.we)
      else $error("reserved access reached a RAM");

   cv_prog_alias: cover property (clk_en && rd_stb && space == SP_PROG && reg_cur == RG_B0);
   cv_boot_read:  cover property (clk_en && rd_stb && reg_cur == RG_BOOT);
   cv_cfg_write:  cover property (clk_en && wr_stb && space == SP_IO && addr == IO_CFG_ADDR);
   cv_sa_data:    cover property (clk_en && wr_stb && space == SP_DATA && reg_cur == RG_SARAM);

endmodule

/* File: mmd_cpu_bfm.sv */
// Core-side bus master model that drives the decoder's memory bus
`timescale 1ns/1ps
module mmd_cpu_bfm
   import mmd_pkg::*;
(
   // Clock
   input  wire logic        ref_clk,
   // Core memory bus
   output mmd_space_t       space,
   output logic [15:0]      addr,
   output logic [15:0]      wr_data,
   output logic             wr_stb,
   output logic             rd_stb,
   input  wire logic [15:0] rd_data_r,
   input  wire mmd_region_t acc_region_r
);
   initial begin
      space   = SP_IO;
      addr    = 16'h0000;
      wr_data = 16'h0000;
      wr_stb  = 1'b0;
      rd_stb  = 1'b0;
   end

   // One strobed access; read data and region are sampled in the answer cycle
   task automatic acc(input mmd_space_t sp, input logic [15:0] a, input logic [15:0] d,
                      input logic w, output logic [15:0] q, output mmd_region_t r);
      @(posedge ref_clk);
      space   <= sp;
      addr    <= a;
      wr_data <= d;
      wr_stb  <= w;
      rd_stb  <= !w;
      @(posedge ref_clk);
      wr_stb  <= 1'b0;
      rd_stb  <= 1'b0;
      // Released bus shows inverted values so a stale address is never reused by luck
      addr    <= ~a;
      wr_data <= ~d;
      @(negedge ref_clk);
      q = rd_data_r;
      r = acc_region_r;
   endtask

   // Write followed by a read with no gap, so a stale word behind an alias shows up
   task automatic wr_rd(input mmd_space_t sp, input logic [15:0] wa, input logic [15:0] d,
                        input logic [15:0] ra, output logic [15:0] q, output mmd_region_t r);
      @(posedge ref_clk);
      space   <= sp;
      addr    <= wa;
      wr_data <= d;
      wr_stb  <= 1'b1;
      @(posedge ref_clk);
      addr    <= ra;
      wr_stb  <= 1'b0;
      rd_stb  <= 1'b1;
      @(posedge ref_clk);
      rd_stb  <= 1'b0;
      addr    <= ~ra;
      wr_data <= ~d;
      @(negedge ref_clk);
      q = rd_data_r;
      r = acc_region_r;
   endtask
endmodule

/* File: tb_top.sv */
// Self-checking testbench for the memory map decoder
`timescale 1ns/1ps
module tb_top;
   import mmd_pkg::*;

   logic        ref_clk;
   logic        rst_n;
   logic        clk_en;
   mmd_space_t  space;
   logic [15:0] addr;
   logic [15:0] wr_data;
   logic        wr_stb;
   logic        rd_stb;
   logic [15:0] rd_data_r;
   mmd_region_t acc_region_r;
   logic        place;
   logic        dsram;
   logic        psram;
   logic        boot;
   logic [15:0] q;
   mmd_region_t rg;
   int          error_cnt;
   int          num_checks;
   int          cyc;

   mmd_decoder i_dut (
      .ref_clk                   (ref_clk),
      .rst_n                     (rst_n),
      .clk_en                    (clk_en),
      .space                     (space),
      .addr                      (addr),
      .wr_data                   (wr_data),
      .wr_stb                    (wr_stb),
      .rd_stb                    (rd_stb),
      .rd_data_r                 (rd_data_r),
      .acc_region_r              (acc_region_r),
      .block_zero_program_place  (place),
      .data_single_ram_enable    (dsram),
      .program_single_ram_enable (psram),
      .boot_rom_enable           (boot)
   );

   mmd_cpu_bfm i_cpu (
      .ref_clk      (ref_clk),
      .space        (space),
      .addr         (addr),
      .wr_data      (wr_data),
      .wr_stb       (wr_stb),
      .rd_stb       (rd_stb),
      .rd_data_r    (rd_data_r),
      .acc_region_r (acc_region_r)
   );

   always #25 ref_clk = ~ref_clk;

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Cut a hang short; the whole run needs well under 400 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask

   task automatic chk_region(input string n, input mmd_region_t e, input mmd_region_t g);
      num_checks++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask

   task automatic acc(input mmd_space_t sp, input logic [15:0] a, input logic [15:0] d,
                      input logic w);
      i_cpu.acc(sp, a, d, w, q, rg);
   endtask

   task automatic wr_rd(input mmd_space_t sp, input logic [15:0] wa, input logic [15:0] d,
                        input logic [15:0] ra);
      i_cpu.wr_rd(sp, wa, d, ra, q, rg);
   endtask

   task automatic cfg(input logic [3:0] bits);
      acc(SP_IO, IO_CFG_ADDR, {12'h000, bits}, 1'b1);
      chk_word("config", {12'h000, bits}, {12'h000, boot, psram, dsram, place});
   endtask

   task automatic t_reset();
      chk_word("reset data", 16'h0000, rd_data_r);
      chk_region("reset region", RG_ILLEGAL, acc_region_r);
      chk_word("reset config", 16'h0000, {12'h000, boot, psram, dsram, place});
   endtask

   task automatic t_data_alias();
      cfg(4'h0);
      wr_rd(SP_DATA, 16'h0100, 16'h1234, 16'h0200);
      chk_word("b0 alias", 16'h1234, q);
      chk_region("b0 region", RG_B0, rg);
      acc(SP_DATA, 16'h02ff, 16'hbeef, 1'b1);
      acc(SP_DATA, 16'h01ff, 16'h0000, 1'b0);
      chk_word("b0 top alias", 16'hbeef, q);
      wr_rd(SP_DATA, 16'h0480, 16'hc0de, 16'h0380);
      chk_word("b1 alias", 16'hc0de, q);
      chk_region("b1 region", RG_B1, rg);
      acc(SP_IO, IO_STAT_ADDR, 16'h0000, 1'b0);
      chk_word("status", {12'h000, RG_B1}, q);
      chk_region("status region", RG_CONFIG, rg);
      // Frozen clock enable must swallow the write
      @(posedge ref_clk) clk_en <= 1'b0;
      acc(SP_DATA, 16'h0380, 16'h5555, 1'b1);
      @(posedge ref_clk) clk_en <= 1'b1;
      acc(SP_DATA, 16'h0480, 16'h0000, 1'b0);
      chk_word("frozen write", 16'hc0de, q);
   endtask

   task automatic t_prog_alias();
      cfg(4'h1);
      wr_rd(SP_PROG, 16'hfe10, 16'ha5a5, 16'hff10);
      chk_word("prog b0 alias", 16'ha5a5, q);
      chk_region("prog b0 region", RG_B0, rg);
      acc(SP_DATA, 16'h0100, 16'h7777, 1'b1);
      acc(SP_DATA, 16'h0100, 16'h0000, 1'b0);
      chk_word("moved b0 data", 16'h0000, q);
      chk_region("moved b0 region", RG_RESERVED, rg);
      cfg(4'h0);
      acc(SP_DATA, 16'h0210, 16'h0000, 1'b0);
      chk_word("b0 shared", 16'ha5a5, q);
      acc(SP_DATA, 16'h0200, 16'h0000, 1'b0);
      chk_word("b0 untouched", 16'h1234, q);
   endtask

   task automatic t_boot();
      logic [15:0] pa [4] = '{16'h003f, 16'h0040, 16'h0043, 16'h0044};
      mmd_region_t pr [4] = '{RG_VECTOR, RG_PASSWORD, RG_PASSWORD, RG_FLASH};
      cfg(4'h0);
      for (int i = 0; i < 4; i++) begin
         acc(SP_PROG, pa[i], 16'h0000, 1'b0);
         chk_region("low program", pr[i], rg);
      end
      acc(SP_PROG, 16'h0041, 16'hffff, 1'b1);
      acc(SP_PROG, 16'h0041, 16'h0000, 1'b0);
      chk_word("password read", 16'h0000, q);
      cfg(4'h8);
      acc(SP_PROG, 16'h0041, 16'h0000, 1'b0);
      chk_word("boot word", {ROM_TAG ^ 8'h41, 8'h41}, q);
      chk_region("boot region", RG_BOOT, rg);
      acc(SP_PROG, 16'h00ff, 16'h0000, 1'b0);
      chk_word("boot top", {ROM_TAG ^ 8'hff, 8'hff}, q);
      // Read data stands for one cycle only
      @(negedge ref_clk);
      chk_word("data cleared", 16'h0000, rd_data_r);
      acc(SP_PROG, 16'h0100, 16'h0000, 1'b0);
      chk_region("above boot", RG_FLASH, rg);
   endtask

   task automatic t_saram();
      cfg(4'h2);
      acc(SP_DATA, 16'h0805, 16'h1111, 1'b1);
      chk_region("saram data", RG_SARAM, rg);
      cfg(4'h0);
      acc(SP_DATA, 16'h0805, 16'h9999, 1'b1);
      chk_region("saram off", RG_RESERVED, rg);
      cfg(4'h2);
      acc(SP_DATA, 16'h0805, 16'h0000, 1'b0);
      chk_word("saram kept", 16'h1111, q);
      acc(SP_DATA, 16'h09ff, 16'h2222, 1'b1);
      acc(SP_PROG, 16'h81ff, 16'h0000, 1'b0);
      chk_word("prog saram off", 16'h0000, q);
      chk_region("prog saram off", RG_RESERVED, rg);
      acc(SP_PROG, 16'h81fe, 16'h3333, 1'b1);
      cfg(4'h6);
      acc(SP_PROG, 16'h81ff, 16'h0000, 1'b0);
      chk_word("prog saram", 16'h2222, q);
      acc(SP_DATA, 16'h09fe, 16'h0000, 1'b0);
      chk_word("prog saram blocked", 16'h0000, q);
      acc(SP_PROG, 16'h81fe, 16'h4444, 1'b1);
      acc(SP_DATA, 16'h09fe, 16'h0000, 1'b0);
      chk_word("prog saram shared", 16'h4444, q);
      cfg(4'h4);
      acc(SP_DATA, 16'h09ff, 16'h0000, 1'b0);
      chk_region("data saram off", RG_RESERVED, rg);
   endtask

   initial begin
      ref_clk    = 1'b0;
      rst_n      = 1'b0;
      clk_en     = 1'b1;
      error_cnt  = 0;
      num_checks = 0;
      cyc        = 0;
      repeat (16) @(posedge ref_clk);
      t_reset();
      rst_n <= 1'b1;
      t_data_alias();
      t_prog_alias();
      t_boot();
      t_saram();
      print_verdict();
   end
endmodule
